// file: rtl/timer8_wave_defs.vh
// Constants for the 8-bit timer waveform mode and compare output control.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
`ifndef TIMER8_WAVE_DEFS_VH
`define TIMER8_WAVE_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define TIMER_CONTROL_B_IDX     8'h18
`define TIMER_CONTROL_A_IDX     8'h19
`define TIMER_CONTROL_B_ADDR    8'h60
`define TIMER_CONTROL_A_ADDR    8'h64
`define ADDR_BITS               8

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CHAN_A_MODE_HI          7
`define CHAN_A_MODE_LO          6
`define CHAN_B_MODE_HI          5
`define CHAN_B_MODE_LO          4
`define WAVEFORM_MODE_HI_BIT    3
`define CLOCK_SELECT_HI         2
`define CLOCK_SELECT_LO         0
`define CONTROL_A_RESET         8'h00
`define CONTROL_B_RESET         8'h00

// ----------------------------------------------------------------------
// Waveform modes and counter limits
// ----------------------------------------------------------------------
`define MODE_NORMAL             3'h0
`define MODE_PC_PWM_FULL        3'h1
`define MODE_CLEAR_ON_MATCH     3'h2
`define MODE_FAST_PWM_FULL      3'h3
`define MODE_RESERVED_4         3'h4
`define MODE_PC_PWM_VAR         3'h5
`define MODE_RESERVED_6         3'h6
`define MODE_FAST_PWM_VAR       3'h7
`define COUNT_MAX               8'hff
`define COUNT_BOTTOM            8'h00

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// file: rtl/timer8_waveform_mode_control.v
// Control registers, waveform mode decode and compare output logic of an
// 8-bit timer. The counter, compare values, direction and timer tick come
// from neighbouring logic on the same clock; port direction and data bits
// come from the port block on the same clock.
`include "timer8_wave_defs.vh"
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// R1 - Nonzero channel A output mode hands the pin over to compare output A, except PWM code 01 with mode high bit 0 (R6).
// R2 - Nonzero channel B output mode hands the pin over to compare output B.
// R3 - Pin driver enabled only while the pin direction bit selects output.
// R4 - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// R5 - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// R6 - PWM channel A code 01: off if mode high bit 0, else toggle on match.
// R7 - Fast PWM A: 10 clear on match set at bottom; 11 the inverse.
// R8 - Fast PWM B: 01 reserved; 10 clear match set bottom; 11 inverse.
// R9 - Fast PWM: compare equal TOP with high code bit ignores match, bottom acts.
// R10 - Phase correct A: 10 clears on up match, sets on down; 11 reverse.
// R11 - Phase correct B: 01 reserved; 10 clear up, set down; 11 reverse.
// R12 - Phase correct: compare equal TOP with high bit ignores match, acts at TOP.
// R13 - Control A bits 3:2 always read zero.
// R14 - Waveform mode is control B high bit with control A bits 1:0.
// R15 - Normal TOP 0xFF, clear-on-match TOP compare A; immediate update; overflow at MAX.
// R16 - Phase correct 1 and 5 load at TOP, overflow at BOTTOM; mode 1 TOP 0xFF.
// R17 - Fast PWM 3 and 7 load at BOTTOM; 3 overflow MAX; 7 TOP compare A.
// R18 - MAX is 0xFF and BOTTOM is 0x00 in all modes.
// R19 - Phase correct mode 5 uses compare A as TOP, counting up then down.
// R20 - Phase correct overflow flag sets whenever counter reaches BOTTOM.
// R21 - Reset clears both control registers: normal mode, outputs disconnected.
// R22 - Compare output actions are evaluated only on timer clock ticks.
module timer8_waveform_mode_control
(
	// Clock and reset
	input  wire        ref_clk_in,
	input  wire        rst_in,
	// AXI4-Lite write address and data
	input  wire [31:0] s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp_out,
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	// AXI4-Lite read
	input  wire [31:0] s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// Counter side
	input  wire        timer_tick_in,
	input  wire [7:0]  counter_value_in,
	input  wire        count_down_in,
	input  wire [7:0]  compare_value_a_in,
	input  wire [7:0]  compare_value_b_in,
	// Port side
	input  wire        pin_dir_a_in,
	input  wire        pin_dir_b_in,
	input  wire        port_data_a_in,
	input  wire        port_data_b_in,
	// Mode results to the counter
	output reg  [7:0]  top_value_out,
	output reg         dual_slope_out,
	output reg         update_immediate_out,
	output reg         compare_load_out,
	output reg         overflow_set_out,
	output reg  [2:0]  clock_select_out,
	// Compare outputs and pins
	output reg         compare_out_a_out,
	output reg         compare_out_b_out,
	output reg         pin_override_a_out,
	output reg         pin_override_b_out,
	output reg         pin_level_a_out,
	output reg         pin_level_b_out,
	output reg         pin_oe_a_out,
	output reg         pin_oe_b_out
);

	// ------------------------------------------------------------------
	// Next compare output level for one channel
	// ------------------------------------------------------------------
	function wave_next;
		input       cur;
		input [1:0] code;
		input [2:0] mode;
		input       is_a;
		input       hit;
		input       eq_top;
		input       at_top;
		input       down;
		reg         r;
		begin
			r = cur;
			case (mode)
				`MODE_NORMAL, `MODE_CLEAR_ON_MATCH:
				begin
					if (hit)
						case (code)
							2'h1:    r = ~cur;
							2'h2:    r = 1'b0;
							2'h3:    r = 1'b1;
							default: r = cur;
						endcase
				end
				`MODE_FAST_PWM_FULL, `MODE_FAST_PWM_VAR:
				begin
					if (code == 2'h1 && is_a && mode[2] && hit)
						r = ~cur;
					else if (code[1])
					begin
						if (hit && !eq_top)
							r = code[0];
						else if (at_top)
							r = ~code[0];
					end
				end
				`MODE_PC_PWM_FULL, `MODE_PC_PWM_VAR:
				begin
					if (code == 2'h1 && is_a && mode[2] && hit)
						r = ~cur;
					else if (code[1])
					begin
						if (eq_top && at_top)
							r = ~code[0];
						else if (hit && !eq_top)
							r = down ? ~code[0] : code[0];
					end
				end
				default: r = cur;
			endcase
			wave_next = r;
		end
	endfunction

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function [1:0] reg_sel;
		input [31:0] addr;
		begin
			if (addr[`ADDR_BITS-1:0] == `TIMER_CONTROL_A_ADDR && addr[31:`ADDR_BITS] == 24'h0)
				reg_sel = 2'h1;
			else if (addr[`ADDR_BITS-1:0] == `TIMER_CONTROL_B_ADDR && addr[31:`ADDR_BITS] == 24'h0)
				reg_sel = 2'h2;
			else
				reg_sel = 2'h0;
		end
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg  [1:0]  chan_a_output_mode_q;
	reg  [1:0]  chan_b_output_mode_q;
	reg  [1:0]  waveform_mode_low_q;
	reg         waveform_mode_hi_q;
	reg  [2:0]  clock_select_q;
	reg         aw_held_q;
	reg         w_held_q;
	reg  [31:0] aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;

	wire [2:0]  waveform_mode;
	wire        fast_pwm;
	wire        pc_pwm;
	wire [7:0]  top_d;
	wire        at_top;
	wire        at_max;
	wire        at_bottom;
	wire        hit_a;
	wire        hit_b;
	wire        eq_top_a;
	wire        eq_top_b;
	wire        next_a;
	wire        next_b;
	wire        a_drives;
	wire        aw_ok;
	wire        w_ok;
	wire        do_write;
	wire [31:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	wire [1:0]  wr_sel;
	wire [1:0]  rd_sel;
	reg  [7:0]  rd_byte;

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	assign waveform_mode = {waveform_mode_hi_q, waveform_mode_low_q}; // R14
	assign fast_pwm = (waveform_mode == `MODE_FAST_PWM_FULL)
		|| (waveform_mode == `MODE_FAST_PWM_VAR); // R17
	assign pc_pwm = (waveform_mode == `MODE_PC_PWM_FULL)
		|| (waveform_mode == `MODE_PC_PWM_VAR); // R16
	assign top_d = (waveform_mode == `MODE_CLEAR_ON_MATCH
		|| waveform_mode == `MODE_PC_PWM_VAR
		|| waveform_mode == `MODE_FAST_PWM_VAR)
		? compare_value_a_in : `COUNT_MAX; // R15 R19

	// Counter events gated by the timer tick; the compare-equals-TOP flags are not
	assign at_top    = timer_tick_in && (counter_value_in == top_d); // R22
	assign at_max    = timer_tick_in && (counter_value_in == `COUNT_MAX); // R18
	assign at_bottom = timer_tick_in && (counter_value_in == `COUNT_BOTTOM); // R18
	assign hit_a     = timer_tick_in && (counter_value_in == compare_value_a_in); // R22
	assign hit_b     = timer_tick_in && (counter_value_in == compare_value_b_in); // R22
	assign eq_top_a  = (compare_value_a_in == top_d) && chan_a_output_mode_q[1]; // R9 R12
	assign eq_top_b  = (compare_value_b_in == top_d) && chan_b_output_mode_q[1]; // R9 R12

	assign next_a = wave_next(compare_out_a_out, chan_a_output_mode_q, waveform_mode,
		1'b1, hit_a, eq_top_a, at_top, count_down_in); // R4 R6 R7 R10
	assign next_b = wave_next(compare_out_b_out, chan_b_output_mode_q, waveform_mode,
		1'b0, hit_b, eq_top_b, at_top, count_down_in); // R5 R8 R11
	assign a_drives = (|chan_a_output_mode_q) && !(chan_a_output_mode_q == 2'h1
		&& (fast_pwm || pc_pwm) && !waveform_mode_hi_q); // R6

	// ------------------------------------------------------------------
	// Bus write path
	// ------------------------------------------------------------------
	assign aw_ok    = s_axi_awvalid_in && s_axi_awready_out;
	assign w_ok     = s_axi_wvalid_in && s_axi_wready_out;
	assign do_write = (aw_held_q || aw_ok) && (w_held_q || w_ok) && !s_axi_bvalid_out;
	assign wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr_in;
	assign wr_data  = w_held_q ? w_data_q : s_axi_wdata_in;
	assign wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb_in;
	assign wr_sel   = reg_sel(wr_addr);
	assign rd_sel   = reg_sel(s_axi_araddr_in);

	always @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `RESP_OKAY;
			aw_held_q         <= 1'b0;
			w_held_q          <= 1'b0;
			aw_addr_q         <= 32'h0;
			w_data_q          <= 32'h0;
			w_strb_q          <= 4'h0;
		end
		else
		begin
			s_axi_awready_out <= !aw_held_q && !aw_ok && !s_axi_bvalid_out && !do_write;
			s_axi_wready_out  <= !w_held_q && !w_ok && !s_axi_bvalid_out && !do_write;
			if (do_write)
			begin
				aw_held_q        <= 1'b0;
				w_held_q         <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= (wr_sel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else
			begin
				if (aw_ok)
				begin
					aw_held_q <= 1'b1;
					aw_addr_q <= s_axi_awaddr_in;
				end
				if (w_ok)
				begin
					w_held_q <= 1'b1;
					w_data_q <= s_axi_wdata_in;
					w_strb_q <= s_axi_wstrb_in;
				end
				if (s_axi_bvalid_out && s_axi_bready_in)
					s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			chan_a_output_mode_q <= 2'h0; // R21
			chan_b_output_mode_q <= 2'h0; // R21
			waveform_mode_low_q  <= 2'h0; // R21
			waveform_mode_hi_q   <= 1'b0; // R21
			clock_select_q       <= 3'h0;
		end
		else if (do_write && wr_strb[0])
		begin
			if (wr_sel == 2'h1)
			begin
				chan_a_output_mode_q <= wr_data[`CHAN_A_MODE_HI:`CHAN_A_MODE_LO];
				chan_b_output_mode_q <= wr_data[`CHAN_B_MODE_HI:`CHAN_B_MODE_LO];
				waveform_mode_low_q  <= wr_data[1:0]; // R14
			end
			if (wr_sel == 2'h2)
			begin
				waveform_mode_hi_q <= wr_data[`WAVEFORM_MODE_HI_BIT]; // R14
				clock_select_q     <= wr_data[`CLOCK_SELECT_HI:`CLOCK_SELECT_LO];
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus read path
	// ------------------------------------------------------------------
	always @*
	begin
		rd_byte = 8'h00;
		if (rd_sel == 2'h1)
			rd_byte = {chan_a_output_mode_q, chan_b_output_mode_q,
				2'b00, waveform_mode_low_q}; // R13
		else if (rd_sel == 2'h2)
			rd_byte = {4'h0, waveform_mode_hi_q, clock_select_q};
	end

	always @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
			if (s_axi_arvalid_in && s_axi_arready_out)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out  <= {24'h0, rd_byte};
				s_axi_rresp_out  <= (rd_sel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (s_axi_rvalid_out && s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Mode results and compare outputs
	// ------------------------------------------------------------------
	always @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			top_value_out        <= `COUNT_MAX;
			dual_slope_out       <= 1'b0;
			update_immediate_out <= 1'b1;
			compare_load_out     <= 1'b0;
			overflow_set_out     <= 1'b0;
			clock_select_out     <= 3'h0;
			compare_out_a_out    <= 1'b0;
			compare_out_b_out    <= 1'b0;
			pin_override_a_out   <= 1'b0;
			pin_override_b_out   <= 1'b0;
			pin_level_a_out      <= 1'b0;
			pin_level_b_out      <= 1'b0;
			pin_oe_a_out         <= 1'b0;
			pin_oe_b_out         <= 1'b0;
		end
		else
		begin
			top_value_out        <= top_d; // R15
			dual_slope_out       <= pc_pwm; // R19
			update_immediate_out <= (waveform_mode == `MODE_NORMAL)
				|| (waveform_mode == `MODE_CLEAR_ON_MATCH); // R15
			compare_load_out     <= (pc_pwm || fast_pwm) && at_top; // R16 R17
			case (waveform_mode)
				`MODE_NORMAL, `MODE_CLEAR_ON_MATCH, `MODE_FAST_PWM_FULL:
					overflow_set_out <= at_max; // R15 R17
				`MODE_FAST_PWM_VAR:
					overflow_set_out <= at_top; // R17
				`MODE_PC_PWM_FULL, `MODE_PC_PWM_VAR:
					overflow_set_out <= at_bottom; // R16 R20
				default:
					overflow_set_out <= 1'b0;
			endcase
			clock_select_out     <= clock_select_q;
			compare_out_a_out    <= next_a;
			compare_out_b_out    <= next_b;
			pin_override_a_out   <= a_drives; // R1 R6
			pin_override_b_out   <= |chan_b_output_mode_q; // R2
			pin_level_a_out      <= a_drives ? next_a : port_data_a_in; // R1
			pin_level_b_out      <= (|chan_b_output_mode_q) ? next_b : port_data_b_in; // R2
			pin_oe_a_out         <= pin_dir_a_in; // R3
			pin_oe_b_out         <= pin_dir_b_in; // R3
		end
	end

endmodule
`default_nettype wire

// file: test/test_timer8_waveform_mode_control.sv
// Self-checking bench for the timer waveform mode block.
// Assumes the counter partner model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module test_timer8_waveform_mode_control;
	reg         clk, rst, awv, wv, bre, arv, rre, lv, done;
	reg  [31:0] awa, wd, ara, d;
	reg  [7:0]  cmp_a, cmp_b;
	reg  [3:0]  pins, pins_q, ws;
	wire        awr, wr, bv, arr, rv, tick, down, dual, imm, ld, ovf, coa, cob;
	wire        ova, ovb, pla, plb, oea, oeb;
	wire [1:0]  br, rr;
	wire [31:0] rd;
	wire [7:0]  cnt, top;
	wire [2:0]  cs;
	integer     seed, fail_count, checks_done, i, n;

	timer8_waveform_mode_control uut (.ref_clk_in(clk), .rst_in(rst),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
		.s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
		.timer_tick_in(tick), .counter_value_in(cnt), .count_down_in(down),
		.compare_value_a_in(cmp_a), .compare_value_b_in(cmp_b), .pin_dir_a_in(pins[0]),
		.pin_dir_b_in(pins[1]), .port_data_a_in(pins[2]), .port_data_b_in(pins[3]),
		.top_value_out(top), .dual_slope_out(dual), .update_immediate_out(imm),
		.compare_load_out(ld), .overflow_set_out(ovf), .clock_select_out(cs),
		.compare_out_a_out(coa), .compare_out_b_out(cob), .pin_override_a_out(ova),
		.pin_override_b_out(ovb), .pin_level_a_out(pla), .pin_level_b_out(plb),
		.pin_oe_a_out(oea), .pin_oe_b_out(oeb));
	timer8_count_partner pm (.clk_in(clk), .rst_in(rst), .top_in(top), .dual_in(dual),
		.tick_out(tick), .count_out(cnt), .down_out(down));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		pins <= $random(seed);
		pins_q <= pins;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	function [7:0] exp_top(input integer md, input [7:0] ca);
		exp_top = (md == 2 || md == 5 || md == 7) ? ca : 8'hff;
	endfunction
	function exp_ovr(input [1:0] c, input [2:0] md);
		exp_ovr = |c && !(c == 2'h1 && md[0] && !md[2]);
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp)
			begin
				fail_count = fail_count + 1;
				$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks=%0d mismatches=%0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task give_up;
		begin
			fail_count = fail_count + 1;
			conclude;
		end
	endtask
	task axi_wr(input [31:0] a, input [31:0] dd, input [1:0] er);
		begin
			awa <= a;
			wd <= dd;
			awv <= 1'b1;
			wv <= 1'b1;
			bre <= 1'b1;
			done = 1'b0;
			for (n = 0; n < 3000 && !done; n = n + 1)
			begin
				@(posedge clk);
				if (awr)
					awv <= 1'b0;
				if (wr)
					wv <= 1'b0;
				if (bv && bre)
				begin
					check(br, er);
					bre <= 1'b0;
					done = 1'b1;
				end
			end
			if (!done)
				give_up;
			@(posedge clk);
		end
	endtask
	task axi_rd(input [31:0] a, input [31:0] ed, input [1:0] er);
		begin
			ara <= a;
			arv <= 1'b1;
			rre <= 1'b1;
			done = 1'b0;
			for (n = 0; n < 3000 && !done; n = n + 1)
			begin
				@(posedge clk);
				if (arr)
					arv <= 1'b0;
				if (rv && rre)
				begin
					check(rd, ed);
					check(rr, er);
					rre <= 1'b0;
					done = 1'b1;
				end
			end
			if (!done)
				give_up;
			@(posedge clk);
		end
	endtask
	task wait_lvl(input s, input v);
		begin
			for (n = 0; n < 3000 && (s ? cob : coa) !== v; n = n + 1)
				@(posedge clk);
			if (n >= 3000)
				give_up;
		end
	endtask
	task hold_chk(input v);
		integer k;
		begin
			k = 0;
			repeat (600)
			begin
				@(posedge clk);
				k = k + (coa !== v);
				k = k + (pla !== (ova ? coa : pins_q[2]));
				k = k + (plb !== pins_q[3]);
			end
			check(k, 0);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 59;
		fail_count = 0;
		checks_done = 0;
		{rst, awv, wv, bre, arv, rre} = 6'h20;
		{awa, wd, ara} = 0;
		ws = 4'hf;
		cmp_a = 8'h80;
		cmp_b = 8'h40;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		axi_rd(32'h64, 0, 2'h0);
		axi_rd(32'h60, 0, 2'h0);
		axi_rd(32'h68, 0, 2'h2);
		axi_wr(32'h6c, 32'hff, 2'h2);
		for (i = 0; i < 6; i = i + 1)
		begin
			d = $random(seed);
			axi_wr(32'h64, d, 2'h0);
			axi_rd(32'h64, d & 32'hf3, 2'h0);
			axi_wr(32'h60, d >> 8, 2'h0);
			axi_rd(32'h60, (d >> 8) & 32'h0f, 2'h0);
			check(cs, d[10:8]);
			check(ova, exp_ovr(d[7:6], {d[11], d[1:0]}));
			check(ovb, |d[5:4]);
		end
		ws <= 4'h0;
		axi_wr(32'h64, 32'hff, 2'h0);
		ws <= 4'hf;
		axi_rd(32'h64, d & 32'hf3, 2'h0);
		for (i = 0; i < 8; i = i + 1)
		begin
			d = $random(seed);
			cmp_a <= d[7:0] | 8'h10;
			axi_wr(32'h60, (i & 4) << 1, 2'h0);
			axi_wr(32'h64, i & 3, 2'h0);
			check(top, exp_top(i, cmp_a));
			check(dual, i == 1 || i == 5);
			check(imm, i == 0 || i == 2);
		end
		cmp_a <= 8'h80;
		axi_wr(32'h60, 0, 2'h0);
		axi_wr(32'h64, 32'ha0, 2'h0);
		wait_lvl(0, 0);
		wait_lvl(1, 0);
		axi_wr(32'h64, 32'hf0, 2'h0);
		wait_lvl(0, 1);
		wait_lvl(1, 1);
		axi_wr(32'h64, 32'h50, 2'h0);
		wait_lvl(0, 0);
		wait_lvl(0, 1);
		for (i = 0; i < 8; i = i + 1)
		begin
			lv = i % 2;
			axi_wr(32'h64, (lv + 2) * 32'h50 + ((i & 2) ? 1 : 3), 2'h0);
			wait_lvl(i >= 4, !lv);
			wait_lvl(i >= 4, lv);
			check({down, cnt >= ((i >= 4) ? cmp_b : cmp_a)}, 1);
		end
		for (i = 0; i < 2; i = i + 1)
		begin
			cmp_a <= 8'h20;
			axi_wr(32'h60, 32'h08, 2'h0);
			axi_wr(32'h64, 32'h80 | (2 * i + 1), 2'h0);
			wait_lvl(0, 1);
			hold_chk(1);
		end
		axi_wr(32'h64, 32'h43, 2'h0);
		wait_lvl(0, 0);
		wait_lvl(0, 1);
		axi_wr(32'h60, 0, 2'h0);
		check(ova, 0);
		d = {31'h0, coa};
		hold_chk(d[0]);
		conclude;
	end
endmodule
`default_nettype wire

// file: test/timer8_count_partner.sv
// Counter-side model: a tick every other clock and an 8-bit counter.
// Assumes TOP and the dual-slope flag come from the block under test.
`timescale 1ns/100ps
`default_nettype none
module timer8_count_partner
(
	// Clock and mode
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [7:0] top_in,
	input  wire logic       dual_in,
	// Counter
	output var  logic       tick_out,
	output var  logic [7:0] count_out,
	output var  logic       down_out
);
	wire logic go_down = down_out ? (count_out != 8'h00) : (count_out >= top_in);
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			tick_out <= 1'b0;
			count_out <= 8'h00;
			down_out <= 1'b0;
		end
		else
		begin
			tick_out <= ~tick_out;
			if (tick_out)
			begin
				down_out <= dual_in & go_down;
				if (!dual_in)
					count_out <= (count_out >= top_in) ? 8'h00 : count_out + 8'h01;
				else if (go_down)
					count_out <= count_out - 8'h01;
				else
					count_out <= count_out + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/timer8_waveform_mode_control_props.sv
// Checker for the timer waveform mode block, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module timer8_waveform_mode_control_props
(
	// Clock, reset and bus
	input wire       ref_clk_in,
	input wire       rst_in,
	input wire       s_axi_bvalid_out,
	input wire       s_axi_bready_in,
	// Counter and port side
	input wire       timer_tick_in,
	input wire [7:0] counter_value_in,
	input wire       count_down_in,
	input wire [7:0] compare_value_a_in,
	input wire       pin_dir_a_in,
	input wire       pin_dir_b_in,
	// Results
	input wire [7:0] top_value_out,
	input wire       dual_slope_out,
	input wire       update_immediate_out,
	input wire       compare_load_out,
	input wire       overflow_set_out,
	input wire       compare_out_a_out,
	input wire       compare_out_b_out,
	input wire       pin_override_a_out,
	input wire       pin_override_b_out,
	input wire       pin_oe_a_out,
	input wire       pin_oe_b_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	a_oe_follows_dir: assert property (!$past(rst_in) && !$past(rst_in, 2) |->
		pin_oe_a_out == $past(pin_dir_a_in) && pin_oe_b_out == $past(pin_dir_b_in))
		else $error("pin enable not following direction bit");
	a_reset_values: assert property ($past(rst_in) |-> top_value_out == 8'hff
		&& update_immediate_out && !dual_slope_out && !pin_override_a_out && !pin_override_b_out)
		else $error("wrong state after reset");
	a_mode_exclusive: assert property (!(update_immediate_out && dual_slope_out))
		else $error("immediate update in dual slope mode");
	a_tick_gates_out: assert property (!$past(timer_tick_in) && !$past(rst_in) && !$past(rst_in, 2)
		|-> $stable(compare_out_a_out) && $stable(compare_out_b_out) && !overflow_set_out)
		else $error("output changed without timer tick");
	a_ovf_at_bottom: assert property (dual_slope_out && !s_axi_bvalid_out && timer_tick_in
		&& count_down_in && counter_value_in == 8'h00 |=> overflow_set_out)
		else $error("no overflow at bottom");
	a_ovf_at_max: assert property (update_immediate_out && !s_axi_bvalid_out && timer_tick_in
		&& counter_value_in == 8'hff |=> overflow_set_out)
		else $error("no overflow at max");
	a_load_at_top: assert property (dual_slope_out && !s_axi_bvalid_out && timer_tick_in
		&& counter_value_in == top_value_out && $stable(compare_value_a_in) |=> compare_load_out)
		else $error("no compare load at top");
	a_no_early_load: assert property (update_immediate_out && !s_axi_bvalid_out |=> !compare_load_out)
		else $error("compare load in immediate mode");
	a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped early");
endmodule
bind timer8_waveform_mode_control timer8_waveform_mode_control_props chk (.ref_clk_in, .rst_in,
	.s_axi_bvalid_out, .s_axi_bready_in, .timer_tick_in, .counter_value_in, .count_down_in,
	.compare_value_a_in,
	.pin_dir_a_in, .pin_dir_b_in, .top_value_out, .dual_slope_out, .update_immediate_out,
	.compare_load_out, .overflow_set_out, .compare_out_a_out, .compare_out_b_out,
	.pin_override_a_out, .pin_override_b_out, .pin_oe_a_out, .pin_oe_b_out);
`default_nettype wire
